// file: verilog/lcd_cmd_consts.svh
/*
  shared constants of the lcd host command decoder.
  assumes inclusion by bare name from the design files.
*/
`ifndef LCD_CMD_CONSTS_SVH
`define LCD_CMD_CONSTS_SVH
`define PAGE_CODE_BASE   8'hB8
`define PAGE_CODE_MASK   8'hF8
`define COL_CODE_BASE    8'h40
`define COL_CODE_MASK    8'hC0
`define LINE_CODE_BASE   8'hC0
`define LINE_CODE_MASK   8'hC0
`define DISP_CODE_BASE   8'h3E
`define DISP_CODE_MASK   8'hFE
`define ST_BUSY_BIT      7
`define ST_OFF_BIT       5
`define ST_RESET_BIT     4
`define COL_LAST         6'h3F
`define COL_ONE          6'h01
`define PAGE_ZERO        3'h0
`define COL_ZERO         6'h00
`define BYTE_ZERO        8'h00
`define RESET_CYCLES     4'hF
`define RESET_START      4'h0
`define RESET_STEP       4'h1
`define BUSY_CYCLES      2'h2
`define BUSY_IDLE        2'h0
`define BUSY_STEP        2'h1
`define MEM_WORDS        512
`endif

// file: verilog/lcd_cmd_pkg.sv
/*
  types of the lcd host command decoder.
  assumes nothing of its surroundings.
*/
`default_nettype none
package lcd_cmd_pkg;
  typedef enum logic [2:0]
  {
    CMD_NONE  = 3'b000,
    CMD_PAGE  = 3'b001,
    CMD_COL   = 3'b010,
    CMD_LINE  = 3'b011,
    CMD_DISP  = 3'b100
  } cmd_t;
endpackage
`default_nettype wire

// file: verilog/lcd_display_ram.sv
/*
  display data memory, 8 pages by 64 columns of bytes.
  assumes a synchronous write and registered read on one clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lcd_cmd_consts.svh"
module lcd_display_ram
(
  input  wire logic       clk,
  input  wire logic       writeEn,
  input  wire logic [8:0] addr,
  input  wire logic [7:0] writeData,
  output var  logic [7:0] readData
);
  logic [7:0] mem [0:`MEM_WORDS-1];

  always_ff @(posedge clk)
  begin
    if (writeEn)
    begin
      mem[addr] <= writeData;
    end
    readData <= mem[addr];
  end
endmodule
`default_nettype wire

// file: verilog/lcd_host_command_decoder.sv
/*
  command decoder, status byte and data path of the lcd column driver.
  assumes host pins enable, cmdData, readWrite and data arrive asynchronously;
  each access is taken at the falling edge of the synchronised enable.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lcd_cmd_consts.svh"
// Overview of operation
// (R1) command write with code B8..BF selects a page
// (R2) low three bits of that code load the page pointer
// (R3) page pointer is three bits, pages zero through seven
// (R4) host programs column with cmdData low and readWrite low
// (R5) command write with code 40..7F loads the column
// (R6) low six bits load the column pointer, zero through sixty-three
// (R7) cmdData low, readWrite high drives status byte on data bus
// (R8) status: busy bit 7, off bit 5, reset bit 4, rest zero
// (R9) busy is one while executing; accesses then are ignored
// (R10) busy reads zero when idle
// (R11) off flag is inverse of stored display enable
// (R12) reset flag is one while reset still in progress
// (R13) data write stores host byte at current page and column
// (R14) data read drives the internal output latch
// (R15) host discards the first read after setting an address
// (R16) 3F turns display on, 3E turns it off
// (R17) codes C0..FF load the start line from low six bits
// (R18) column increments and wraps after each data access
// (R19) data read returns old latch, then reloads it from memory
module lcd_host_command_decoder
  import lcd_cmd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       enable,
  input  wire logic       cmdData,
  input  wire logic       readWrite,
  input  wire logic [7:0] dataIn,
  output var  logic [7:0] dataOut,
  output var  logic       dataOe,
  output var  logic       displayOn,
  output var  logic [5:0] startLine,
  output var  logic [2:0] pagePtr,
  output var  logic [5:0] columnPtr
);
  logic [1:0] enSync;
  logic [1:0] cdSync;
  logic [1:0] rwSync;
  logic [7:0] dSync0;
  logic [7:0] dSync1;
  logic       enPrev;
  logic [3:0] resetCount;
  logic [1:0] busyCount;
  logic       reloadPend;
  logic [7:0] outLatch;
  logic [7:0] ramRead;
  logic       ramWrite;
  logic       accessEnd;
  logic       accepted;
  logic       resetBusy;
  logic       busy;
  logic [7:0] statusByte;
  cmd_t       cmd;

  function automatic cmd_t decode(input logic [7:0] code);
    if ((code & `PAGE_CODE_MASK) == `PAGE_CODE_BASE)
      decode = CMD_PAGE;
    else if ((code & `COL_CODE_MASK) == `COL_CODE_BASE)
      decode = CMD_COL;
    else if ((code & `LINE_CODE_MASK) == `LINE_CODE_BASE)
      decode = CMD_LINE;
    else if ((code & `DISP_CODE_MASK) == `DISP_CODE_BASE)
      decode = CMD_DISP;
    else
      decode = CMD_NONE;
  endfunction

  // pins are double-registered before any decode
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      enSync <= 2'h0;
      cdSync <= 2'h0;
      rwSync <= 2'h0;
      dSync0 <= `BYTE_ZERO;
      dSync1 <= `BYTE_ZERO;
      enPrev <= 1'b0;
    end
    else
    begin
      enSync <= {enSync[0], enable};
      cdSync <= {cdSync[0], cmdData};
      rwSync <= {rwSync[0], readWrite};
      dSync0 <= dataIn;
      dSync1 <= dSync0;
      enPrev <= enSync[1];
    end
  end

  assign accessEnd = enPrev && !enSync[1];
  assign resetBusy = resetCount != `RESET_CYCLES;
  assign busy      = resetBusy || (busyCount != `BUSY_IDLE) || reloadPend;
  assign accepted  = accessEnd && !busy; // R9
  assign cmd       = decode(dSync1);
  assign ramWrite  = accepted && cdSync[1] && !rwSync[1]; // R13

  always_comb
  begin
    statusByte                = `BYTE_ZERO; // R8
    statusByte[`ST_BUSY_BIT]  = busy; // R9 R10
    statusByte[`ST_OFF_BIT]   = !displayOn; // R11
    statusByte[`ST_RESET_BIT] = resetBusy; // R12
  end

  // internal reset sequence runs a few cycles after the pin reset lifts
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      resetCount <= `RESET_START;
    else if (resetBusy)
      resetCount <= resetCount + `RESET_STEP;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      busyCount <= `BUSY_IDLE;
    else if (accepted)
      busyCount <= `BUSY_CYCLES;
    else if (busyCount != `BUSY_IDLE)
      busyCount <= busyCount - `BUSY_STEP;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      displayOn <= 1'b0;
      startLine <= `COL_ZERO;
    end
    else if (accepted && !cdSync[1] && !rwSync[1]) // R4
    begin
      if (cmd == CMD_DISP)
        displayOn <= dSync1[0]; // R16
      if (cmd == CMD_LINE)
        startLine <= dSync1[5:0]; // R17
    end
  end

  // page pointer: three bits only, so it can never leave zero..seven
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pagePtr <= `PAGE_ZERO;
    else if (accepted && !cdSync[1] && !rwSync[1] && cmd == CMD_PAGE) // R1
      pagePtr <= dSync1[2:0]; // R2 R3
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      columnPtr <= `COL_ZERO;
    else if (accepted && !cdSync[1] && !rwSync[1] && cmd == CMD_COL) // R5
      columnPtr <= dSync1[5:0]; // R6
    else if (accepted && cdSync[1])
      columnPtr <= (columnPtr == `COL_LAST) ? `COL_ZERO : columnPtr + `COL_ONE; // R18
  end

  // latch reload waits one cycle for the registered ram read
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reloadPend <= 1'b0;
      outLatch   <= `BYTE_ZERO;
    end
    else
    begin
      reloadPend <= accepted && cdSync[1] && rwSync[1];
      if (reloadPend)
        outLatch <= ramRead; // R19
    end
  end

  // bus drive follows the strobe; the latch seen is the one before reload
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dataOut <= `BYTE_ZERO;
      dataOe  <= 1'b0;
    end
    else
    begin
      dataOe  <= enSync[1] && rwSync[1];
      dataOut <= cdSync[1] ? outLatch : statusByte; // R7 R14
    end
  end

  lcd_display_ram u_ram
  (
    .clk       (clk),
    .writeEn   (ramWrite),
    .addr      ({pagePtr, columnPtr}),
    .writeData (dSync1),
    .readData  (ramRead)
  );

  sequence s_cmd_write;
    accepted && !cdSync[1] && !rwSync[1];
  endsequence

  sequence s_data_read;
    accepted && cdSync[1] && rwSync[1];
  endsequence

  a_page_load: assert property (@(posedge clk) disable iff (!arst_n)
    accepted && !cdSync[1] && !rwSync[1] && cmd == CMD_PAGE |=> pagePtr == $past(dSync1[2:0])) // R2
    else $error("page pointer not loaded");
  a_col_wrap: assert property (@(posedge clk) disable iff (!arst_n)
    accepted && cdSync[1] && columnPtr == `COL_LAST |=> columnPtr == `COL_ZERO) // R18
    else $error("column did not wrap");
  // a refused strobe must leave every stored setting untouched
  a_busy_block: assert property (@(posedge clk) disable iff (!arst_n) // R9
    accessEnd && busy |=> $stable(pagePtr) && $stable(columnPtr) && $stable(displayOn) && $stable(startLine))
    else $error("access taken while busy");
  a_status_off: assert property (@(posedge clk) disable iff (!arst_n)
    enSync[1] && !cdSync[1] && rwSync[1] |=> dataOut[`ST_OFF_BIT] == !$past(displayOn)) // R11
    else $error("off flag wrong");
  a_status_zero: assert property (@(posedge clk) disable iff (!arst_n)
    enSync[1] && !cdSync[1] && rwSync[1] |=> dataOut[6] == 1'b0 && dataOut[3:0] == 4'h0) // R8
    else $error("reserved status bits set");
  a_busy_idle: assert property (@(posedge clk) disable iff (!arst_n)
    accepted |-> ##[1:4] !busy) // R10
    else $error("busy stuck");
  a_reset_flag: assert property (@(posedge clk) disable iff (!arst_n) // R12
    resetBusy |-> ##[1:15] !resetBusy)
    else $error("reset flag stuck");
  a_disp_cmd: assert property (@(posedge clk) disable iff (!arst_n) // R16
    s_cmd_write ##0 cmd == CMD_DISP |=> displayOn == $past(dSync1[0]))
    else $error("display switch ignored");
  a_read_start: assert property (@(posedge clk) disable iff (!arst_n) // R19 R9
    s_data_read |=> reloadPend && busy)
    else $error("latch reload not started");
  a_line_load: assert property (@(posedge clk) disable iff (!arst_n)
    accepted && !cdSync[1] && !rwSync[1] && cmd == CMD_LINE |=> startLine == $past(dSync1[5:0])) // R17
    else $error("start line not loaded");
  a_read_lag: assert property (@(posedge clk) disable iff (!arst_n)
    reloadPend |=> outLatch == $past(ramRead)) // R19
    else $error("latch not reloaded");
endmodule
`default_nettype wire

// file: tb/lcd_host_model.sv
/*
  host model driving the decoder's parallel bus pins.
  assumes clk from the bench; paces accesses by strobe spacing.
*/
`timescale 1ns/10ps
`default_nettype none
module lcd_host_model
(
  input  wire logic       clk,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe,
  output var  logic       enable,
  output var  logic       cmdData,
  output var  logic       readWrite,
  output var  logic [7:0] dataIn
);
  initial
  begin
    enable = 1'b0;
    cmdData = 1'b0;
    readWrite = 1'b0;
    dataIn = 8'h00;
  end
  // 20 clocks high and 22 low keep the 1050ns cycle
  task automatic access(input logic cd, input logic rw, input logic [7:0] d,
                        input int hi, output logic [7:0] q);
    @(posedge clk);
    cmdData <= cd;
    readWrite <= rw;
    dataIn <= d;
    @(posedge clk);
    enable <= 1'b1;
    repeat (hi - 1) @(posedge clk);
    // sample mid-cycle, clear of the edge that updates the bus
    @(negedge clk);
    q = dataOe ? dataOut : 8'hXX;
    @(posedge clk);
    enable <= 1'b0;
    repeat (6) @(posedge clk);
    dataIn <= ~d; // released bus must not show a stale byte
    repeat (14) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: tb/lcd_host_command_decoder_tb.sv
/*
  self-checking bench of lcd_host_command_decoder.
  assumes the host model spaces op accesses 42 clocks apart, and the two reset status polls 28.
*/
`timescale 1ns/10ps
`default_nettype none
module lcd_host_command_decoder_tb;
  logic        clk, arst_n, enable, cmdData, readWrite, dataOe, displayOn;
  logic [7:0]  dataIn, dataOut, q, a, b;
  logic [5:0]  startLine, columnPtr;
  logic [2:0]  pagePtr, pg;
  logic [31:0] seed;
  int          mismatches, cmp_count, cycles;

  lcd_host_command_decoder i_dut (.clk(clk), .arst_n(arst_n), .enable(enable),
    .cmdData(cmdData), .readWrite(readWrite), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .displayOn(displayOn), .startLine(startLine),
    .pagePtr(pagePtr), .columnPtr(columnPtr));
  lcd_host_model i_host (.clk(clk), .dataOut(dataOut), .dataOe(dataOe), .enable(enable),
    .cmdData(cmdData), .readWrite(readWrite), .dataIn(dataIn));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xorshift = v ^ (v << 5);
  endfunction

  task automatic rnd;
    seed = xorshift(seed);
  endtask

  // status byte as the rules lay it out: busy 7, off 5, reset 4
  function automatic logic [7:0] exp_status(input logic bsy, input logic off, input logic rst);
    exp_status = {bsy, 1'b0, off, rst, 4'h0};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic op(input logic cd, input logic rw, input logic [7:0] d);
    i_host.access(cd, rw, d, 20, q);
  endtask

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // whole run is near 2600 clocks
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      mismatches++;
      $display("MISMATCH t=%0t run hung", $time);
      report_and_stop;
    end
  end

  initial
  begin
    arst_n = 1'b0;
    seed = 32'h33FF;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    i_host.access(1'b0, 1'b1, 8'h00, 6, q);
    chk(q, exp_status(1'b1, 1'b1, 1'b1));
    repeat (30) @(posedge clk);
    op(1'b0, 1'b1, 8'h00);
    chk(q, exp_status(1'b0, 1'b1, 1'b0));
    op(1'b0, 1'b0, 8'h3F);
    op(1'b0, 1'b1, 8'h00);
    chk(q, exp_status(1'b0, 1'b0, 1'b0));
    chk({7'h00, displayOn}, 8'h01);
    op(1'b0, 1'b0, 8'h3E);
    op(1'b0, 1'b1, 8'h00);
    chk(q, exp_status(1'b0, 1'b1, 1'b0));
    $display("status and display test done");
    for (int i = 0; i < 8; i++)
    begin
      op(1'b0, 1'b0, 8'hB8 | i[7:0]);
      chk({5'h00, pagePtr}, i[7:0]);
    end
    for (int i = 0; i < 6; i++)
    begin
      rnd;
      op(1'b0, 1'b0, {2'b01, seed[5:0]});
      chk({2'b00, columnPtr}, {2'b00, seed[5:0]});
      op(1'b0, 1'b0, {2'b11, seed[13:8]});
      chk({2'b00, startLine}, {2'b00, seed[13:8]});
    end
    // unknown code: nothing may move
    op(1'b0, 1'b0, 8'h1D);
    chk({2'b00, columnPtr}, {2'b00, seed[5:0]});
    chk({2'b00, startLine}, {2'b00, seed[13:8]});
    chk({5'h00, pagePtr}, 8'h07);
    $display("pointer test done");
    // column 63 each time so the wrap is always crossed
    for (int i = 0; i < 4; i++)
    begin
      rnd;
      pg = seed[2:0];
      a = seed[15:8];
      b = seed[23:16];
      op(1'b0, 1'b0, {5'b10111, pg});
      op(1'b0, 1'b0, 8'h7F);
      op(1'b1, 1'b0, a);
      op(1'b1, 1'b0, b);
      chk({2'b00, columnPtr}, 8'h01);
      chk({5'h00, pagePtr}, {5'h00, pg});
      op(1'b0, 1'b0, 8'h7F);
      op(1'b1, 1'b1, 8'h00);
      op(1'b1, 1'b1, 8'h00);
      chk(q, a);
      op(1'b1, 1'b1, 8'h00);
      chk(q, b);
    end
    $display("data test done");
    // second reset in mid-run
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    chk({5'h00, pagePtr}, 8'h00);
    chk({2'b00, columnPtr}, 8'h00);
    i_host.access(1'b0, 1'b1, 8'h00, 6, q);
    chk(q, exp_status(1'b1, 1'b1, 1'b1));
    chk({7'h00, displayOn}, 8'h00);
    repeat (30) @(posedge clk);
    op(1'b0, 1'b1, 8'h00);
    chk(q, exp_status(1'b0, 1'b1, 1'b0));
    $display("reset test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
